// *** dasrs_params.svh ***
// Constants for the accumulator store, round, saturate and shift datapath
`ifndef DASRS_PARAMS_SVH
`define DASRS_PARAMS_SVH
`define DASRS_ACC_W 40
`define DASRS_WORD_W 16
`define DASRS_SIGN_BIT 39
`define DASRS_HI_LSB 16
`define DASRS_HI_MSB 31
`define DASRS_LO_MSB 15
`define DASRS_HALF_LSW 16'h8000
`define DASRS_POS_MAX 16'h7fff
`define DASRS_NEG_MAX 16'h8000
`define DASRS_SAT_HI 40'sh00_0000_7fff
`define DASRS_SAT_LO 40'shff_ffff_8000
`define DASRS_SHIFT_MAX 16
`define DASRS_SHAMT_W 6
`endif

// *** dasrs_pkg.sv ***
// Types for the accumulator store, round, saturate and shift datapath
package dasrs_pkg;
   typedef enum logic [1:0] {
      dasrs_src_acca,
      dasrs_src_accb,
      dasrs_src_xbus
   } dasrs_src_t;
   typedef enum logic [1:0] {
      dasrs_st_idle,
      dasrs_st_store
   } dasrs_state_t;
endpackage : dasrs_pkg

// *** dasrs_datapath.sv ***
// Accumulator store path with rounding, write saturation and a 40-bit barrel shifter
//
// Summary of operation
// - Round mode bit picks conventional or convergent
// - Round logic yields 16-bit 1.15 word
// - No rounding: store high word, drop low
// - Conventional adds bit 15 to high word
// - Low word 8000..ffff increments high word
// - Convergent at exactly 8000 uses bit 16
// - Truncating and rounding stores pass saturation
// - Multiply-accumulate writeback is always rounded
// - Saturation never alters the source accumulator
// - Saturation uses rounded word and overflow status
// - Above 007fff clamps to 7fff
// - Below ff8000 clamps to 8000
// - Operand sign taken from bit 39
// - Saturation disabled passes word unchanged
// - Single-cycle shifts up to 16 bits
// - Shift source is either accumulator or X bus
// - Signed amount: positive right, negative left
// - 40-bit shifter, 40 or 16-bit result
// - X bus at 16..31 right, 0..15 left
`timescale 1ns/1ps
`include "dasrs_params.svh"
module dasrs_datapath (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic round_mode_select_i,
   input wire logic data_write_saturate_enable_i,
   input wire logic store_valid_i,
   input wire logic store_accum_truncated_i,
   input wire logic store_accum_rounded_i,
   input wire logic multiply_accumulate_class_i,
   input wire logic store_acc_sel_i,
   input wire logic [39:0] acca_i,
   input wire logic [39:0] accb_i,
   input wire logic [15:0] xbus_i,
   input wire logic shift_valid_i,
   input wire logic [1:0] shift_src_i,
   input wire logic signed [5:0] shift_amount_i,
   input wire logic shift_arith_i,
   output logic [15:0] store_data_o,
   output logic store_write_o,
   output logic store_saturated_o,
   output logic [39:0] shift_result_o,
   output logic [15:0] shift_word_o,
   output logic shift_done_o
);

   // Combinational round/saturate path

   logic [39:0] store_acc;
   logic [15:0] acc_hi;
   logic [15:0] acc_lo;
   logic do_round;
   logic round_inc;
   logic [16:0] round_sum;
   logic [15:0] rounded_word;
   logic round_ovf;
   logic signed [39:0] post_round;
   logic acc_sign;
   logic sat_pos;
   logic sat_neg;
   logic [15:0] store_word;

   // Source accumulator is only read here, never written back
   assign store_acc = store_acc_sel_i ? accb_i : acca_i;
   assign acc_hi = store_acc[`DASRS_HI_MSB:`DASRS_HI_LSB];
   assign acc_lo = store_acc[`DASRS_LO_MSB:0];

   // Accumulate-class writeback forces rounding
   assign do_round = store_accum_rounded_i | multiply_accumulate_class_i;

   always_comb begin
      round_inc = 1'b0;
      if (do_round) begin
         round_inc = store_acc[`DASRS_LO_MSB];
         if (round_mode_select_i && (acc_lo == `DASRS_HALF_LSW)) begin
            round_inc = store_acc[`DASRS_HI_LSB];
         end
      end
   end

   // Truncation adds zero, so the low word has no influence
   assign round_sum = {1'b0, acc_hi} + {16'h0000, round_inc};
   assign rounded_word = round_sum[15:0];
   assign round_ovf = round_inc & (acc_hi == `DASRS_POS_MAX);

   // Post-round value is the guard bits and high word, sign-extended from bit 39
   assign acc_sign = store_acc[`DASRS_SIGN_BIT];
   assign post_round = $signed({{16{acc_sign}}, store_acc[`DASRS_SIGN_BIT:`DASRS_HI_LSB]})
      + $signed({39'h0, round_inc});

   always_comb begin
      sat_pos = 1'b0;
      sat_neg = 1'b0;
      if (data_write_saturate_enable_i) begin
         if (!acc_sign && (round_ovf || post_round > `DASRS_SAT_HI)) begin
            sat_pos = 1'b1;
         end else if (acc_sign && post_round < `DASRS_SAT_LO) begin
            sat_neg = 1'b1;
         end
      end
   end

   always_comb begin
      store_word = rounded_word;
      if (sat_pos) begin
         store_word = `DASRS_POS_MAX;
      end else if (sat_neg) begin
         store_word = `DASRS_NEG_MAX;
      end
   end

   logic store_req;
   assign store_req = store_valid_i &
      (store_accum_truncated_i | store_accum_rounded_i | multiply_accumulate_class_i);

   // No pipeline stage: data leaves in the request cycle
   assign store_data_o = store_word;
   assign store_write_o = store_req;
   assign store_saturated_o = store_req & (sat_pos | sat_neg);

   // Barrel shifter

   function automatic logic [39:0] dasrs_shift(input logic [39:0] opnd,
                                               input logic signed [5:0] amt,
                                               input logic arith);
      logic [5:0] mag;
      logic [39:0] res;
      mag = amt[5] ? 6'(-amt) : 6'(amt);
      if (mag > 6'(`DASRS_SHIFT_MAX)) begin
         mag = 6'(`DASRS_SHIFT_MAX);
      end
      if (amt == 6'sd0) begin
         res = opnd;
      end else if (!amt[5]) begin
         res = arith ? 40'($signed(opnd) >>> mag) : (opnd >> mag);
      end else begin
         res = opnd << mag;
      end
      return res;
   endfunction : dasrs_shift

   logic [39:0] shift_opnd;
   logic [39:0] shift_next;

   always_comb begin
      shift_opnd = acca_i;
      if (shift_src_i == 2'(dasrs_pkg::dasrs_src_accb)) begin
         shift_opnd = accb_i;
      end else if (shift_src_i == 2'(dasrs_pkg::dasrs_src_xbus)) begin
         if (!shift_amount_i[5]) begin
            shift_opnd = {{8{shift_arith_i & xbus_i[15]}}, xbus_i, 16'h0000};
         end else begin
            shift_opnd = {24'h00_0000, xbus_i};
         end
      end else begin
         shift_opnd = acca_i;
      end
   end

   assign shift_next = dasrs_shift(shift_opnd, shift_amount_i, shift_arith_i);

   logic [39:0] shift_result_reg;
   logic [15:0] shift_word_reg;
   logic shift_done_reg;

   // Result captured at the end of the single shift cycle
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         shift_result_reg <= 40'h00_0000_0000;
         shift_word_reg <= 16'h0000;
      end else if (shift_valid_i) begin
         shift_result_reg <= shift_next;
         shift_word_reg <= shift_amount_i[5] ? shift_next[15:0]
                                               : shift_next[31:16];
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         shift_done_reg <= 1'b0;
      end else begin
         shift_done_reg <= shift_valid_i;
      end
   end

   assign shift_result_o = shift_result_reg;
   assign shift_word_o = shift_word_reg;
   assign shift_done_o = shift_done_reg;

   // Assertions

   property p_round_conv;
      @(posedge core_clk_i) disable iff (reset_i)
      (store_write_o && store_accum_rounded_i && !round_mode_select_i &&
       !data_write_saturate_enable_i)
      |-> store_data_o == 16'(acc_hi + {15'h0000, store_acc[15]});
   endproperty
   a_round_conv: assert property (p_round_conv) else $error("conventional round wrong");

   property p_round_tie;
      @(posedge core_clk_i) disable iff (reset_i)
      (store_write_o && do_round && round_mode_select_i && acc_lo == 16'h8000 &&
       !data_write_saturate_enable_i)
      |-> store_data_o == 16'(acc_hi + {15'h0000, store_acc[16]});
   endproperty
   a_round_tie: assert property (p_round_tie) else $error("convergent tie wrong");

   property p_trunc;
      @(posedge core_clk_i) disable iff (reset_i)
      (store_write_o && !do_round && !data_write_saturate_enable_i)
      |-> store_data_o == acc_hi;
   endproperty
   a_trunc: assert property (p_trunc) else $error("truncated store wrong");

   property p_mac_round;
      @(posedge core_clk_i) disable iff (reset_i)
      (store_write_o && multiply_accumulate_class_i && !round_mode_select_i &&
       !data_write_saturate_enable_i && acc_lo == 16'h8000)
      |-> store_data_o == 16'(acc_hi + 16'h0001);
   endproperty
   a_mac_round: assert property (p_mac_round) else $error("accumulate store not rounded");

   property p_sat_pos;
      @(posedge core_clk_i) disable iff (reset_i)
      (store_write_o && data_write_saturate_enable_i && !store_acc[39] &&
       store_acc[38:31] != 8'h00)
      |-> store_data_o == 16'h7fff;
   endproperty
   a_sat_pos: assert property (p_sat_pos) else $error("positive clamp missing");

   property p_sat_neg;
      @(posedge core_clk_i) disable iff (reset_i)
      (store_write_o && data_write_saturate_enable_i && store_acc[39] &&
       store_acc[38:31] != 8'hff)
      |-> store_data_o == 16'h8000;
   endproperty
   a_sat_neg: assert property (p_sat_neg) else $error("negative clamp missing");

   property p_no_sat;
      @(posedge core_clk_i) disable iff (reset_i)
      !data_write_saturate_enable_i |-> store_data_o == rounded_word && !store_saturated_o;
   endproperty
   a_no_sat: assert property (p_no_sat) else $error("data altered with saturation off");

   property p_shift_zero;
      @(posedge core_clk_i) disable iff (reset_i)
      (shift_valid_i && shift_amount_i == 6'sd0 && shift_src_i == 2'd0)
      |=> shift_result_o == $past(acca_i) && shift_done_o;
   endproperty
   a_shift_zero: assert property (p_shift_zero) else $error("zero shift modified operand");

   property p_shift_left_one;
      @(posedge core_clk_i) disable iff (reset_i)
      (shift_valid_i && shift_amount_i == -6'sd1 && shift_src_i == 2'd1)
      |=> shift_result_o == {$past(accb_i[38:0]), 1'b0};
   endproperty
   a_shift_left_one: assert property (p_shift_left_one) else $error("left shift wrong");

   property p_store_write;
      @(posedge core_clk_i) disable iff (reset_i)
      (store_valid_i && (store_accum_truncated_i || store_accum_rounded_i))
      |-> store_write_o;
   endproperty
   a_store_write: assert property (p_store_write) else $error("store request not written");

   property p_sign_neg;
      @(posedge core_clk_i) disable iff (reset_i)
      (store_write_o && data_write_saturate_enable_i && store_acc[39])
      |-> store_data_o != 16'h7fff;
   endproperty
   a_sign_neg: assert property (p_sign_neg) else $error("negative operand clamped high");

   property p_sign_pos;
      @(posedge core_clk_i) disable iff (reset_i)
      (store_write_o && data_write_saturate_enable_i && !store_acc[39])
      |-> store_data_o != 16'h8000;
   endproperty
   a_sign_pos: assert property (p_sign_pos) else $error("positive operand clamped low");

   property p_sat_value;
      @(posedge core_clk_i) disable iff (reset_i)
      store_saturated_o
      |-> (store_data_o == 16'h7fff || store_data_o == 16'h8000);
   endproperty
   a_sat_value: assert property (p_sat_value) else $error("clamp value wrong");

   property p_round_ovf;
      @(posedge core_clk_i) disable iff (reset_i)
      (store_write_o && data_write_saturate_enable_i && !store_acc[39] &&
       acc_hi == 16'h7fff && round_inc) |-> store_data_o == 16'h7fff;
   endproperty
   a_round_ovf: assert property (p_round_ovf) else $error("round overflow not clamped");

   property p_xbus_right;
      @(posedge core_clk_i) disable iff (reset_i)
      (shift_valid_i && shift_src_i == 2'd2 && !shift_arith_i && shift_amount_i == 6'sd16)
      |=> shift_result_o == {24'h00_0000, $past(xbus_i)};
   endproperty
   a_xbus_right: assert property (p_xbus_right) else $error("bus right placement wrong");

   property p_xbus_left;
      @(posedge core_clk_i) disable iff (reset_i)
      (shift_valid_i && shift_src_i == 2'd2 && shift_amount_i == -6'sd16)
      |=> shift_result_o == {8'h00, $past(xbus_i), 16'h0000};
   endproperty
   a_xbus_left: assert property (p_xbus_left) else $error("bus left placement wrong");

   property p_logic_right;
      @(posedge core_clk_i) disable iff (reset_i)
      (shift_valid_i && shift_src_i == 2'd0 && !shift_arith_i && shift_amount_i == 6'sd1)
      |=> shift_result_o == {1'b0, $past(acca_i[39:1])};
   endproperty
   a_logic_right: assert property (p_logic_right) else $error("logical right fill wrong");

   property p_arith_right;
      @(posedge core_clk_i) disable iff (reset_i)
      (shift_valid_i && shift_src_i == 2'd0 && shift_arith_i && shift_amount_i == 6'sd1)
      |=> shift_result_o == {$past(acca_i[39]), $past(acca_i[39:1])};
   endproperty
   a_arith_right: assert property (p_arith_right) else $error("sign fill wrong");

   property p_shift_done;
      @(posedge core_clk_i) disable iff (reset_i)
      shift_valid_i
      |=> shift_done_o;
   endproperty
   a_shift_done: assert property (p_shift_done) else $error("shift done missing");

   property p_shift_hold;
      @(posedge core_clk_i) disable iff (reset_i)
      !shift_valid_i
      |=> $stable(shift_result_o);
   endproperty
   a_shift_hold: assert property (p_shift_hold) else $error("shift result changed idle");

   property p_shift_word;
      @(posedge core_clk_i) disable iff (reset_i)
      shift_valid_i |=> shift_word_o ==
      ($past(shift_amount_i[5]) ? shift_result_o[15:0] : shift_result_o[31:16]);
   endproperty
   a_shift_word: assert property (p_shift_word) else $error("shift word slice wrong");

   c_round_tie: cover property (@(posedge core_clk_i) disable iff (reset_i)
      store_write_o && round_mode_select_i && acc_lo == 16'h8000);
   c_sat: cover property (@(posedge core_clk_i) disable iff (reset_i) store_saturated_o);
   c_xbus_right: cover property (@(posedge core_clk_i) disable iff (reset_i)
      shift_valid_i && shift_src_i == 2'd2 && shift_amount_i > 6'sd0);
   c_back_to_back: cover property (@(posedge core_clk_i) disable iff (reset_i)
      shift_valid_i ##1 shift_valid_i);

endmodule : dasrs_datapath

// *** dasrs_acc_model.sv ***
// Far-side model: accumulators and X bus feeding the store and shift paths
`timescale 1ns/1ps
module dasrs_acc_model (
   input wire logic shift_valid_i,
   input wire logic [1:0] shift_src_i,
   output logic [39:0] acca_o,
   output logic [39:0] accb_o,
   output logic [15:0] xbus_o
);
   logic [15:0] xbus_reg = 16'h0000;
   initial begin
      acca_o = 40'h00_0000_0000;
      accb_o = 40'h00_0000_0000;
   end
   // X bus carries data only while the shifter reads it, otherwise the inverse
   assign xbus_o = (shift_valid_i && shift_src_i == dasrs_pkg::dasrs_src_xbus) ? xbus_reg
                   : ~xbus_reg;
   task automatic load(input logic [39:0] a, input logic [39:0] b, input logic [15:0] x);
      acca_o = a;
      accb_o = b;
      xbus_reg = x;
   endtask : load
endmodule : dasrs_acc_model

// *** dsp_accum_store_round_sat_shift_test.sv ***
// Self-checking bench for the store, round, saturate and shift datapath
`timescale 1ns/1ps
`include "dasrs_params.svh"
module dsp_accum_store_round_sat_shift_test;
   logic core_clk_i = 1'b0, reset_i = 1'b1, rmode = 1'b0, sat_en = 1'b0, st_valid = 1'b0;
   logic st_tr = 1'b0, st_rn = 1'b0, st_mac = 1'b0, st_sel = 1'b0, sh_valid = 1'b0;
   logic sh_arith = 1'b0;
   logic [1:0] sh_src = 2'h0;
   logic signed [5:0] sh_amt = 6'sh00;
   logic [39:0] acca, accb, sh_res;
   logic [15:0] xbus, st_data, sh_word;
   logic st_write, st_satd, sh_done;
   int fail_count = 0, check_count = 0;
   dasrs_acc_model u_dasrs_acc_model (.shift_valid_i(sh_valid), .shift_src_i(sh_src),
      .acca_o(acca), .accb_o(accb), .xbus_o(xbus));
   dasrs_datapath u_dasrs_datapath (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .round_mode_select_i(rmode), .data_write_saturate_enable_i(sat_en),
      .store_valid_i(st_valid), .store_accum_truncated_i(st_tr), .store_accum_rounded_i(st_rn),
      .multiply_accumulate_class_i(st_mac), .store_acc_sel_i(st_sel), .acca_i(acca),
      .accb_i(accb), .xbus_i(xbus), .shift_valid_i(sh_valid), .shift_src_i(sh_src),
      .shift_amount_i(sh_amt), .shift_arith_i(sh_arith), .store_data_o(st_data),
      .store_write_o(st_write), .store_saturated_o(st_satd), .shift_result_o(sh_res),
      .shift_word_o(sh_word), .shift_done_o(sh_done));
   initial begin
      forever #25 core_clk_i = ~core_clk_i;
   end
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [16:0] exp_store(logic [39:0] a, logic rnd, logic conv, logic sat);
      logic signed [24:0] h;
      logic inc;
      inc = rnd & a[15] & !(conv && a[15:0] == 16'h8000 && !a[16]);
      h = $signed(a[39:16]) + $signed({24'h000000, inc});
      if (sat && h > 25'sh000_7fff) return {1'b1, `DASRS_POS_MAX};
      if (sat && h < 25'sh1ff_8000) return {1'b1, `DASRS_NEG_MAX};
      return {1'b0, h[15:0]};
   endfunction : exp_store
   task automatic store(input logic [39:0] a, input logic sel, input logic [2:0] kind,
                        input logic mode, input logic sat);
      @(posedge core_clk_i);
      #5;
      u_dasrs_acc_model.load(sel ? ~a : a, sel ? a : ~a, 16'h0000);
      {st_tr, st_rn, st_mac} = kind;
      {st_valid, st_sel, rmode, sat_en} = {1'b1, sel, mode, sat};
      #1;
      check(st_write, |kind);
      if (|kind) check({st_satd, st_data}, exp_store(a, |kind[1:0], mode, sat));
      else check(st_satd, 1'b0);
   endtask : store
   task automatic test_round;
      logic [39:0] v[5] = '{40'h00_1234_7fff, 40'h00_1234_8000, 40'h00_1235_8000,
                           40'h00_1234_ffff, 40'hff_fffe_8001};
      for (int m = 0; m < 2; m++) begin
         for (int i = 0; i < 5; i++) begin
            store(v[i], i[0], 3'h4, m[0], 1'b1);
            store(v[i], i[0], 3'h2, m[0], m[0]);
            store(v[i], ~i[0], 3'h1, m[0], 1'b0);
         end
      end
      $display("test_round done");
   endtask : test_round
   task automatic test_sat;
      logic [39:0] v[5] = '{40'h00_7fff_8000, 40'h01_0000_0000, 40'hff_8000_0000,
                           40'hff_7fff_ffff, 40'h80_0000_0000};
      for (int s = 0; s < 2; s++) begin
         for (int i = 0; i < 5; i++) begin
            store(v[i], i[0], 3'h4, 1'b0, s[0]);
            store(v[i], ~i[0], 3'h2, 1'b1, s[0]);
            store(v[i], i[0], 3'h0, 1'b0, s[0]);
         end
      end
      st_valid = 1'b0;
      $display("test_sat done");
   endtask : test_sat
   task automatic test_shift;
      logic [39:0] op, r;
      logic [39:0] av = 40'h9a_5c3e_71b8, bv = 40'h3b_c1a7_e24d;
      logic [15:0] xv = 16'hb3c5;
      for (int s = 0; s < 3; s++) begin
         for (int ar = 0; ar < 2; ar++) begin
            for (int k = -16; k <= 16; k++) begin
               if (s == 2 && k == 0) continue;
               @(posedge core_clk_i);
               #5;
               u_dasrs_acc_model.load(av, bv, xv);
               {sh_valid, sh_src, sh_arith, sh_amt} = {1'b1, s[1:0], ar[0], k[5:0]};
               op = (s == 0) ? av : (s == 1) ? bv : (k > 0) ?
                    {{8{ar[0] & xv[15]}}, xv, 16'h0000} : {24'h000000, xv};
               r = (k < 0) ? op << -k : ar[0] ? 40'($signed(op) >>> k) : op >> k;
               @(posedge core_clk_i);
               #5;
               sh_valid = 1'b0;
               check(sh_done, 1'b1);
               check(sh_res, r);
               if (k != 0) check(sh_word, (k > 0) ? r[31:16] : r[15:0]);
            end
         end
      end
      @(posedge core_clk_i);
      #5;
      check(sh_done, 1'b0);
      $display("test_shift done");
   endtask : test_shift
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   initial begin
      #2_000_000;
      fail_count++;
      stop_test();
   end
   initial begin
      repeat (10) @(posedge core_clk_i);
      #5;
      check(sh_done, 1'b0);
      check(sh_res, 40'h00_0000_0000);
      reset_i = 1'b0;
      test_round();
      test_sat();
      test_shift();
      stop_test();
   end
endmodule : dsp_accum_store_round_sat_shift_test
